// file: pkg/ida_pkg.sv
// package for the indirect data addressing unit
// assumes an 8-bit data path and a sectored data ram with 8-bit offsets
package ida_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int OFFSET_W = 8;
    localparam int SECTOR_W = 3;
    localparam int ADDR_W = SECTOR_W + OFFSET_W;
    // ------------------------------------------------------------
    // special-area offsets (sector 0)
    // ------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] ADDR_PORT_SECTOR0 = 8'h00;
    localparam logic [OFFSET_W-1:0] ADDR_POINTER_SECTOR0 = 8'h01;
    localparam logic [OFFSET_W-1:0] ADDR_PORT_A = 8'h02;
    localparam logic [OFFSET_W-1:0] ADDR_POINTER_A_LOW = 8'h03;
    localparam logic [OFFSET_W-1:0] ADDR_POINTER_A_SECTOR = 8'h04;
    localparam logic [OFFSET_W-1:0] ADDR_PORT_B = 8'h05;
    localparam logic [OFFSET_W-1:0] ADDR_POINTER_B_LOW = 8'h06;
    localparam logic [OFFSET_W-1:0] ADDR_POINTER_B_SECTOR = 8'h07;
    // ------------------------------------------------------------
    // reset values and fixed answers
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PORT_READ_VALUE = 8'h00;
    localparam logic [SECTOR_W-1:0] SECTOR_ZERO = 3'h0;
    // ------------------------------------------------------------
    // address resolution class
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IDA_TGT_RAM = 2'b00,
        IDA_TGT_PTR = 2'b01,
        IDA_TGT_NULL = 2'b10
    } ida_target_t;
endpackage : ida_pkg

// file: pkg/ida_res_if.sv
// interface carrying one address-resolution request and its answer
// assumes the resolver is purely combinational
`timescale 1ns/1ps
interface ida_res_if;
    import ida_pkg::*;
    logic [ADDR_W-1:0] addr;
    ida_target_t target;
    logic [2:0] ptr_sel;
    modport req(output addr, input target, input ptr_sel);
    modport rsp(input addr, output target, output ptr_sel);
endinterface : ida_res_if

// file: sim/ida_ram_model.sv
// sectored data ram standing at the far side of the indirect addressing unit
// assumes combinational read from addr_in and a write at the rising clock edge
`timescale 1ns/1ps
module ida_ram_model
    import ida_pkg::*;
(
    input wire logic clk_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
    logic [DATA_W-1:0] last_q = 8'h00;
    // known pattern so untouched cells still give checkable data
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
    end
    // write at the edge, remember the last value read
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (rd_in) begin
            last_q <= mem[addr_in];
        end
    end
    // an unselected ram shows the inverse of its last answer, never stale data
    always_comb rdata_out = rd_in ? mem[addr_in] : ~last_q;
endmodule : ida_ram_model

// file: sim/tb_ida_unit.sv
// self-checking testbench for the indirect data addressing unit
// assumes the ram model from ida_ram_model and the sector 0 map of ida_pkg
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_ida_unit;
    import ida_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cpu_rd_in = 1'b0;
    logic cpu_wr_in = 1'b0;
    logic cpu_ext_in = 1'b0;
    logic [ADDR_W-1:0] cpu_addr_in = 11'h000;
    logic [DATA_W-1:0] cpu_wdata_in = 8'h00;
    logic [DATA_W-1:0] cpu_rdata_out, ram_wdata_out, ram_rdata_in;
    logic [ADDR_W-1:0] ram_addr_out;
    logic ram_rd_out, ram_wr_out;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // design, ram and clock
    // ------------------------------------------------------------
    ida_unit u_ida_unit (.clk_in(clk_in), .reset_in(reset_in), .cpu_rd_in(cpu_rd_in),
        .cpu_wr_in(cpu_wr_in), .cpu_ext_in(cpu_ext_in), .cpu_addr_in(cpu_addr_in),
        .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
        .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out),
        .ram_wdata_out(ram_wdata_out), .ram_rdata_in(ram_rdata_in));
    ida_ram_model u_ida_ram_model (.clk_in(clk_in), .addr_in(ram_addr_out),
        .rd_in(ram_rd_out), .wr_in(ram_wr_out), .wdata_in(ram_wdata_out),
        .rdata_out(ram_rdata_in));
    always #12.5 clk_in = ~clk_in;
    // ------------------------------------------------------------
    // bus cycles and closing
    // ------------------------------------------------------------
    // one access cycle; outputs are sampled once the launching edge has settled
    task cyc(input logic rd, input logic wr, input logic ext, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        cpu_rd_in <= rd;
        cpu_wr_in <= wr;
        cpu_ext_in <= ext;
        cpu_addr_in <= a;
        cpu_wdata_in <= d;
        #2;
    endtask : cyc
    task wr(input logic ext, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cyc(1'b0, 1'b1, ext, a, d);
    endtask : wr
    task rd(input logic ext, input logic [ADDR_W-1:0] a);
        cyc(1'b1, 1'b0, ext, a, 8'h00);
    endtask : rd
    task close_out;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // five pointers: reset value, write, read back, increment
    task t_pointers;
        logic [DATA_W-1:0] v;
        for (int i = 1; i < 8; i++) if (i != 2 && i != 5) begin
            rd(1'b0, 11'(i)); `CHK(cpu_rdata_out, POINTER_RESET)
            `CHK(ram_rd_out, 1'b0)
            wr(1'b0, 11'(i), 8'(8'h30 + i));
            rd(1'b0, 11'(i));
            v = cpu_rdata_out;
            wr(1'b0, 11'(i), v + 8'h01);
            rd(1'b0, 11'(i)); `CHK(cpu_rdata_out, 8'(8'h31 + i))
        end
    endtask : t_pointers
    // sector 0 port: redirect, back-to-back pointer use, sector forced to 0
    task t_port0;
        wr(1'b0, 11'h001, 8'h10);
        wr(1'b0, 11'h000, 8'hA5); `CHK(ram_addr_out, 11'h010)
        `CHK(ram_wr_out, 1'b1)
        `CHK(ram_wdata_out, 8'hA5)
        rd(1'b0, 11'h000); `CHK(cpu_rdata_out, 8'hA5)
        wr(1'b0, 11'h004, 8'h03);
        wr(1'b0, 11'h001, 8'hF0);
        rd(1'b1, 11'h000); `CHK(ram_addr_out, 11'h0F0)
        `CHK(cpu_rdata_out, 8'hF0 ^ 8'h5A)
    endtask : t_port0
    // paired pointers pick the sector; direct access reads the same cell
    task t_port_ab;
        wr(1'b0, 11'h004, 8'h01);
        wr(1'b0, 11'h003, 8'hF0);
        wr(1'b0, 11'h002, 8'h3C); `CHK(ram_addr_out, 11'h1F0)
        rd(1'b1, 11'h1F0); `CHK(cpu_rdata_out, 8'h3C)
        wr(1'b0, 11'h007, 8'h07);
        wr(1'b0, 11'h006, 8'h22);
        rd(1'b0, 11'h005); `CHK(ram_addr_out, 11'h722)
        `CHK(cpu_rdata_out, 8'h22 ^ 8'h5A)
    endtask : t_port_ab
    // direct access to a high sector, then a short address stays in sector 0
    task t_ext;
        wr(1'b1, 11'h5AB, 8'h77); `CHK(ram_addr_out, 11'h5AB)
        rd(1'b1, 11'h5AB); `CHK(cpu_rdata_out, 8'h77)
        rd(1'b0, 11'h5AB); `CHK(ram_addr_out, 11'h0AB)
        `CHK(cpu_rdata_out, 8'hAB ^ 8'h5A)
    endtask : t_ext
    // pointers aimed at a port: reads give zero, writes go nowhere
    task t_null;
        logic [DATA_W-1:0] offs [3];
        offs = '{ADDR_PORT_SECTOR0, ADDR_PORT_A, ADDR_PORT_B};
        wr(1'b0, 11'h004, 8'h00);
        foreach (offs[k]) begin
            wr(1'b0, 11'h003, offs[k]);
            rd(1'b0, 11'h002); `CHK(cpu_rdata_out, PORT_READ_VALUE)
            `CHK(ram_rd_out, 1'b0)
            wr(1'b0, 11'h002, 8'hEE); `CHK(ram_wr_out, 1'b0)
        end
        wr(1'b0, 11'h001, 8'h00);
        wr(1'b0, 11'h000, 8'hEE); `CHK(ram_wr_out, 1'b0)
        rd(1'b0, 11'h000); `CHK(cpu_rdata_out, PORT_READ_VALUE)
        rd(1'b0, 11'h003); `CHK(cpu_rdata_out, 8'h05)
        rd(1'b0, 11'h001); `CHK(cpu_rdata_out, 8'h00)
    endtask : t_null
    // a reset in mid-run returns written pointers to their reset value
    task t_reset;
        wr(1'b0, 11'h006, 8'h44);
        @(posedge clk_in);
        cpu_wr_in <= 1'b0;
        reset_in <= 1'b1;
        @(posedge clk_in);
        reset_in <= 1'b0;
        rd(1'b0, 11'h006); `CHK(cpu_rdata_out, POINTER_RESET)
        rd(1'b0, 11'h003); `CHK(cpu_rdata_out, POINTER_RESET)
    endtask : t_reset
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        t_pointers;
        t_port0;
        t_port_ab;
        t_ext;
        t_null;
        t_reset;
        cyc(1'b0, 1'b0, 1'b0, 11'h000, 8'h00);
        close_out;
    end
endmodule : tb_ida_unit

// file: src/ida_resolve.sv
// classifies a full data address: pointer register, indirect port or plain ram
// assumes ports and pointers live only at the low offsets of sector 0
`timescale 1ns/1ps
module ida_resolve
    import ida_pkg::*;
(
    ida_res_if.rsp res
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // sector in the high bits, offset in the low 8
    always_comb begin
        res.target = IDA_TGT_RAM;
        res.ptr_sel = 3'h0;
        if (res.addr[ADDR_W-1:OFFSET_W] == SECTOR_ZERO) begin
            case (res.addr[OFFSET_W-1:0])
                ADDR_PORT_SECTOR0, ADDR_PORT_A, ADDR_PORT_B: res.target = IDA_TGT_NULL;
                ADDR_POINTER_SECTOR0: begin
                    res.target = IDA_TGT_PTR;
                    res.ptr_sel = 3'h0;
                end
                ADDR_POINTER_A_LOW: begin
                    res.target = IDA_TGT_PTR;
                    res.ptr_sel = 3'h1;
                end
                ADDR_POINTER_A_SECTOR: begin
                    res.target = IDA_TGT_PTR;
                    res.ptr_sel = 3'h2;
                end
                ADDR_POINTER_B_LOW: begin
                    res.target = IDA_TGT_PTR;
                    res.ptr_sel = 3'h3;
                end
                ADDR_POINTER_B_SECTOR: begin
                    res.target = IDA_TGT_PTR;
                    res.ptr_sel = 3'h4;
                end
                default: res.target = IDA_TGT_RAM;
            endcase
        end
    end
endmodule : ida_resolve

// file: src/ida_unit.sv
// indirect data addressing unit: pointers, indirect ports, ram steering
// assumes cpu strobes are synchronous to clk_in; ram read data is combinational
`timescale 1ns/1ps
module ida_unit
    import ida_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cpu_rd_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_ext_in,
    input wire logic [ADDR_W-1:0] cpu_addr_in,
    input wire logic [DATA_W-1:0] cpu_wdata_in,
    output logic [DATA_W-1:0] cpu_rdata_out,
    output logic [ADDR_W-1:0] ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output logic [DATA_W-1:0] ram_wdata_out,
    input wire logic [DATA_W-1:0] ram_rdata_in
);
    // ------------------------------------------------------------
    // pointer registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] pointer_sector0;
    logic [DATA_W-1:0] pointer_a_low;
    logic [DATA_W-1:0] pointer_a_sector;
    logic [DATA_W-1:0] pointer_b_low;
    logic [DATA_W-1:0] pointer_b_sector;
    logic [DATA_W-1:0] next_pointer_sector0;
    logic [DATA_W-1:0] next_pointer_a_low;
    logic [DATA_W-1:0] next_pointer_a_sector;
    logic [DATA_W-1:0] next_pointer_b_low;
    logic [DATA_W-1:0] next_pointer_b_sector;
    logic [ADDR_W-1:0] cpu_addr_eff;
    logic [ADDR_W-1:0] eff_addr;
    logic is_port;
    ida_res_if first_res();
    ida_res_if final_res();

    // ------------------------------------------------------------
    // first stage: what the cpu named
    // ------------------------------------------------------------
    // plain direct instructions only name sector 0
    assign cpu_addr_eff = cpu_ext_in ? cpu_addr_in
                                     : {SECTOR_ZERO, cpu_addr_in[OFFSET_W-1:0]};
    assign first_res.addr = cpu_addr_eff;
    ida_resolve u_first (.res(first_res));
    assign is_port = (first_res.target == IDA_TGT_NULL);

    // redirect a port to its pointer, read live this cycle
    always_comb begin
        eff_addr = cpu_addr_eff;
        if (is_port) begin
            case (cpu_addr_eff[OFFSET_W-1:0])
                ADDR_PORT_SECTOR0: eff_addr = {SECTOR_ZERO, pointer_sector0};
                ADDR_PORT_A: eff_addr = {pointer_a_sector[SECTOR_W-1:0], pointer_a_low};
                ADDR_PORT_B: eff_addr = {pointer_b_sector[SECTOR_W-1:0], pointer_b_low};
                default: eff_addr = cpu_addr_eff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // second stage: where the access really lands
    // ------------------------------------------------------------
    assign final_res.addr = eff_addr;
    ida_resolve u_final (.res(final_res));

    // ram steering; pointer and port targets never reach the ram
    always_comb begin
        ram_addr_out = eff_addr;
        ram_wdata_out = cpu_wdata_in;
        ram_rd_out = cpu_rd_in && (final_res.target == IDA_TGT_RAM);
        ram_wr_out = cpu_wr_in && (final_res.target == IDA_TGT_RAM);
    end

    // read data: pointer contents, zero when a pointer aims at a port, else ram
    always_comb begin
        cpu_rdata_out = PORT_READ_VALUE;
        if (cpu_rd_in) begin
            case (final_res.target)
                IDA_TGT_RAM: cpu_rdata_out = ram_rdata_in;
                IDA_TGT_PTR: begin
                    case (final_res.ptr_sel)
                        3'h0: cpu_rdata_out = pointer_sector0;
                        3'h1: cpu_rdata_out = pointer_a_low;
                        3'h2: cpu_rdata_out = pointer_a_sector;
                        3'h3: cpu_rdata_out = pointer_b_low;
                        3'h4: cpu_rdata_out = pointer_b_sector;
                        default: cpu_rdata_out = PORT_READ_VALUE;
                    endcase
                end
                default: cpu_rdata_out = PORT_READ_VALUE;
            endcase
        end
    end

    // next pointer values; a write through a port may land on a pointer
    always_comb begin
        next_pointer_sector0 = pointer_sector0;
        next_pointer_a_low = pointer_a_low;
        next_pointer_a_sector = pointer_a_sector;
        next_pointer_b_low = pointer_b_low;
        next_pointer_b_sector = pointer_b_sector;
        if (cpu_wr_in && final_res.target == IDA_TGT_PTR) begin
            case (final_res.ptr_sel)
                3'h0: next_pointer_sector0 = cpu_wdata_in;
                3'h1: next_pointer_a_low = cpu_wdata_in;
                3'h2: next_pointer_a_sector = cpu_wdata_in;
                3'h3: next_pointer_b_low = cpu_wdata_in;
                3'h4: next_pointer_b_sector = cpu_wdata_in;
                default: next_pointer_sector0 = pointer_sector0;
            endcase
        end
    end

    // pointer registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pointer_sector0 <= POINTER_RESET;
            pointer_a_low <= POINTER_RESET;
            pointer_a_sector <= POINTER_RESET;
            pointer_b_low <= POINTER_RESET;
            pointer_b_sector <= POINTER_RESET;
        end else begin
            pointer_sector0 <= next_pointer_sector0;
            pointer_a_low <= next_pointer_a_low;
            pointer_a_sector <= next_pointer_a_sector;
            pointer_b_low <= next_pointer_b_low;
            pointer_b_sector <= next_pointer_b_sector;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // redirect targets and sector limits
    a_port0_sector_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_rd_in && is_port && cpu_addr_eff[OFFSET_W-1:0] == ADDR_PORT_SECTOR0)
        |-> ram_addr_out[ADDR_W-1:OFFSET_W] == SECTOR_ZERO)
        else $error("port sector0 left sector 0");
    a_porta_target: assert property (@(posedge clk_in) disable iff (reset_in)
        (is_port && cpu_addr_eff[OFFSET_W-1:0] == ADDR_PORT_A)
        |-> ram_addr_out == {pointer_a_sector[SECTOR_W-1:0], pointer_a_low})
        else $error("port a address wrong");
    a_portb_target: assert property (@(posedge clk_in) disable iff (reset_in)
        (is_port && cpu_addr_eff[OFFSET_W-1:0] == ADDR_PORT_B)
        |-> ram_addr_out == {pointer_b_sector[SECTOR_W-1:0], pointer_b_low})
        else $error("port b address wrong");
    a_port_no_store: assert property (@(posedge clk_in) disable iff (reset_in)
        is_port |-> ram_addr_out != cpu_addr_eff || final_res.target == IDA_TGT_NULL)
        else $error("port access not redirected");
    a_short_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (!cpu_ext_in && !is_port)
        |-> ram_addr_out == {SECTOR_ZERO, cpu_addr_in[OFFSET_W-1:0]})
        else $error("short address left sector 0");
    a_ext_direct: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_ext_in && cpu_wr_in && final_res.target == IDA_TGT_RAM && !is_port)
        |-> ram_wr_out && ram_addr_out == cpu_addr_in)
        else $error("extended access misrouted");
    // refused accesses and plain ram traffic
    a_self_read_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_rd_in && final_res.target == IDA_TGT_NULL) |-> cpu_rdata_out == 8'h00)
        else $error("self read not zero");
    a_self_write_drop: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && final_res.target == IDA_TGT_NULL)
        |-> !ram_wr_out ##1 $stable(pointer_sector0) && $stable(pointer_a_low)
            && $stable(pointer_a_sector) && $stable(pointer_b_low)
            && $stable(pointer_b_sector))
        else $error("self write not dropped");
    a_null_no_ram: assert property (@(posedge clk_in) disable iff (reset_in)
        final_res.target != IDA_TGT_RAM |-> !ram_rd_out && !ram_wr_out)
        else $error("ram strobed for a non-ram target");
    a_ram_read_pass: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_rd_in && final_res.target == IDA_TGT_RAM)
        |-> ram_rd_out && cpu_rdata_out == ram_rdata_in)
        else $error("ram read not passed through");
    // pointers behave as ordinary registers and are used as they stand
    a_ptr_write_read: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_SECTOR0)
        |=> pointer_sector0 == $past(cpu_wdata_in))
        else $error("pointer write lost");
    a_ptra_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_A_LOW)
        |=> pointer_a_low == $past(cpu_wdata_in))
        else $error("pointer a low write lost");
    a_ptra_sector_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_A_SECTOR)
        |=> pointer_a_sector == $past(cpu_wdata_in))
        else $error("pointer a sector write lost");
    a_ptrb_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_B_LOW)
        |=> pointer_b_low == $past(cpu_wdata_in))
        else $error("pointer b low write lost");
    a_ptrb_sector_write: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_B_SECTOR)
        |=> pointer_b_sector == $past(cpu_wdata_in))
        else $error("pointer b sector write lost");
    a_ptr_read_back: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_rd_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_B_SECTOR)
        |-> cpu_rdata_out == pointer_b_sector)
        else $error("pointer read back wrong");
    // reset in the antecedent keeps the cycle of a reset release out of the check
    a_ptr_hold: assert property (@(posedge clk_in) disable iff (reset_in)
        (!cpu_wr_in && !reset_in) |=> $stable(pointer_sector0) && $stable(pointer_a_low)
            && $stable(pointer_a_sector) && $stable(pointer_b_low)
            && $stable(pointer_b_sector))
        else $error("pointer changed without a write");
    a_live_pointer: assert property (@(posedge clk_in) disable iff (reset_in)
        (cpu_wr_in && !cpu_ext_in && cpu_addr_in[OFFSET_W-1:0] == ADDR_POINTER_SECTOR0)
        ##1 (is_port && cpu_addr_eff[OFFSET_W-1:0] == ADDR_PORT_SECTOR0)
        |-> ram_addr_out[OFFSET_W-1:0] == $past(cpu_wdata_in))
        else $error("stale pointer used");
endmodule : ida_unit
